// [logic/psc_ctrl.sv]
// Host controller for the asynchronous pseudo-static RAM, with command FIFO
`timescale 1ns/1ps

// Command FIFO with valid and ready on both sides
module psc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW:0] wr_ptr_ff;  // Write pointer with wrap bit
    logic [AW:0] rd_ptr_ff;  // Read pointer with wrap bit
    logic push;
    logic pop;
    logic full;
    logic empty;

    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr_ff[AW-1:0]];
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;

    // Storage writes need no reset
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule : psc_fifo

// How it works
// R1: Hold select high 200 us after power
// R2: Write happens while select and strobe low
// R3: Byte enables chosen before write strobe falls
// R4: Write ends by raising strobe then select; here both rise on the same edge
// R5: Break sustained access before 40 us
// R6: Host stops driving data outside writes
// R7: Sleep low, strobe low within 1 us, 10 us
// R8: Sleep loses data; standby needs no wait
// R9: Wait 200 us after leaving deep sleep
// R10: Lane enables pick bytes written or read
// R11: Wake by raising sleep, flag data lost
module psc_ctrl #(
    parameter int POWERUP_CYCLES = psc_pkg::POWERUP_CYC,
    parameter int WAKE_CYCLES = psc_pkg::WAKE_CYC,
    parameter int BURST_CYCLES = psc_pkg::BURST_MAX_CYC,
    parameter int SLEEP_CYCLES = psc_pkg::SLEEP_MIN_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Command side: write flag, high lane, low lane, address, data
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic cmd_high_i,
    input wire logic cmd_low_i,
    input wire logic [psc_pkg::ADDR_W-1:0] cmd_addr_i,
    input wire logic [psc_pkg::DATA_W-1:0] cmd_wdata_i,
    // Read answer and power control
    output logic rd_valid_o,
    output logic [psc_pkg::DATA_W-1:0] rd_data_o,
    input wire logic sleep_req_i,
    output logic ready_o,
    output logic data_lost_o,
    // Memory pins
    output logic ram_select_n_o,
    output logic ram_read_drive_n_o,
    output logic ram_write_strobe_n_o,
    output logic high_lane_enable_n_o,
    output logic low_lane_enable_n_o,
    output logic sleep_request_n_o,
    output logic [psc_pkg::ADDR_W-1:0] ram_addr_o,
    output logic [psc_pkg::DATA_W-1:0] ram_data_o,
    output logic ram_data_oe_o,
    input wire logic [psc_pkg::DATA_W-1:0] ram_data_i
);
    import psc_pkg::*;

    psc_state_t state_ff;  // Controller state
    logic [CNT_W-1:0] cnt_ff;  // Phase timer
    logic [CNT_W-1:0] burst_ff;  // Back-to-back access time
    logic [CMD_W-1:0] cur_ff;  // Command being run
    logic q_valid;
    logic q_ready;
    logic [CMD_W-1:0] q_data;
    logic take;
    logic spent;  // Burst budget used up, so the next idle beat is a rest

    // Commands queue here so the source stalls only once the FIFO_DEPTH queue is full
    psc_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(cmd_valid_i),
        .in_ready_o(cmd_ready_o),
        .in_data_i({cmd_write_i, cmd_high_i, cmd_low_i, cmd_addr_i, cmd_wdata_i}),
        .out_valid_o(q_valid),
        .out_ready_i(q_ready),
        .out_data_o(q_data)
    );

    // R5: a spent burst holds the queue for one idle beat with select high
    assign spent = burst_ff >= CNT_W'(BURST_CYCLES - ACC_CYC - GAP_CYC);
    // Sleep has priority over queued work at an idle point
    assign take = (state_ff == PSC_IDLE) && q_valid && !sleep_req_i && !spent
        && (q_data[CMD_HI_BIT] || q_data[CMD_LO_BIT]);
    // Commands with no lane are dropped rather than stalling the queue
    assign q_ready = (state_ff == PSC_IDLE) && q_valid && !sleep_req_i && !spent;

    // State sequencing and phase timer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_ff <= PSC_POWERUP;
            cnt_ff <= CNT_ZERO;
        end else begin
            case (state_ff)
                // R1: power-up hold
                PSC_POWERUP: begin
                    if (cnt_ff == CNT_W'(POWERUP_CYCLES - 1)) begin
                        state_ff <= PSC_IDLE;
                        cnt_ff <= CNT_ZERO;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                PSC_IDLE: begin
                    cnt_ff <= CNT_ZERO;
                    if (sleep_req_i) begin
                        state_ff <= PSC_SLEEPWE;
                    end else if (take) begin
                        state_ff <= PSC_ACCESS;
                    end
                end
                // Access lasts a full minimum cycle
                PSC_ACCESS: begin
                    if (cnt_ff == CNT_W'(ACC_CYC - 1)) begin
                        state_ff <= PSC_GAP;
                        cnt_ff <= CNT_ZERO;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                // Select-high gap between accesses
                PSC_GAP: begin
                    if (cnt_ff == CNT_W'(GAP_CYC - 1)) begin
                        state_ff <= PSC_IDLE;
                        cnt_ff <= CNT_ZERO;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                // R7: strobe low well inside the 1 us window
                PSC_SLEEPWE: begin
                    if (cnt_ff == CNT_W'(SLEEP_WE_CYC - 1)) begin
                        state_ff <= PSC_SLEEP;
                        cnt_ff <= CNT_ZERO;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                // R7: least sleep time before wake is honoured
                PSC_SLEEP: begin
                    if (cnt_ff != CNT_W'(SLEEP_CYCLES - 1)) begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end else if (!sleep_req_i) begin
                        state_ff <= PSC_WAKE;
                        cnt_ff <= CNT_ZERO;
                    end
                end
                // R9: recovery wait after deep sleep only
                PSC_WAKE: begin
                    if (cnt_ff == CNT_W'(WAKE_CYCLES - 1)) begin
                        state_ff <= PSC_IDLE;
                        cnt_ff <= CNT_ZERO;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                default: begin
                    state_ff <= PSC_POWERUP;
                    cnt_ff <= CNT_ZERO;
                end
            endcase
        end
    end

    // R5: wall time since the last rest; an idle beat without a take is a rest
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            burst_ff <= CNT_ZERO;
        end else if (state_ff == PSC_ACCESS || state_ff == PSC_GAP || take) begin
            burst_ff <= burst_ff + 1'b1;
        end else if (state_ff == PSC_IDLE) begin
            burst_ff <= CNT_ZERO;
        end
    end

    // Latch the command when it is taken
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cur_ff <= '0;
        end else if (take) begin
            cur_ff <= q_data;
        end
    end

    // Memory control pins, all registered
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ram_select_n_o <= 1'b1;
            ram_read_drive_n_o <= 1'b1;
            ram_write_strobe_n_o <= 1'b1;
            high_lane_enable_n_o <= 1'b1;
            low_lane_enable_n_o <= 1'b1;
            sleep_request_n_o <= 1'b1;
            ram_addr_o <= '0;
            ram_data_o <= '0;
            ram_data_oe_o <= 1'b0;
        end else begin
            // R8: sleep pin low only in deep sleep states
            sleep_request_n_o <= !(state_ff == PSC_SLEEPWE || state_ff == PSC_SLEEP);
            // Select low from the take through the last access beat
            ram_select_n_o <= !(take || (state_ff == PSC_ACCESS && cnt_ff != CNT_W'(ACC_CYC - 1)));
            if (take) begin
                ram_addr_o <= q_data[DATA_W +: ADDR_W];
                ram_data_o <= q_data[DATA_W-1:0];
                // R10: lanes chosen from the command
                high_lane_enable_n_o <= !q_data[CMD_HI_BIT];
                low_lane_enable_n_o <= !q_data[CMD_LO_BIT];
                // R3: lanes set before strobe; R6: drive data on writes only
                ram_data_oe_o <= q_data[CMD_WR_BIT];
                ram_read_drive_n_o <= q_data[CMD_WR_BIT];
            end else if (state_ff == PSC_ACCESS && cnt_ff == CNT_W'(ACC_CYC - 1)) begin
                high_lane_enable_n_o <= 1'b1;
                low_lane_enable_n_o <= 1'b1;
                ram_read_drive_n_o <= 1'b1;
                ram_data_oe_o <= 1'b0;
            end
            // R2: strobe low inside select, for the full pulse width
            if (state_ff == PSC_ACCESS && cur_ff[CMD_WR_BIT] && cnt_ff < CNT_W'(WP_CYC)) begin
                ram_write_strobe_n_o <= 1'b0;
            // R7: strobe low during sleep entry
            end else if (state_ff == PSC_SLEEPWE) begin
                ram_write_strobe_n_o <= 1'b0;
            end else begin
                // R4: strobe rises on the same edge as select, after the last access beat
                ram_write_strobe_n_o <= 1'b1;
            end
        end
    end

    // Read capture at the end of the access, status flags
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
            ready_o <= 1'b0;
            data_lost_o <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            if (state_ff == PSC_ACCESS && !cur_ff[CMD_WR_BIT] && cnt_ff == CNT_W'(ACC_CYC - 1)) begin
                rd_valid_o <= 1'b1;
                rd_data_o <= ram_data_i;
            end
            ready_o <= (state_ff == PSC_IDLE || state_ff == PSC_ACCESS || state_ff == PSC_GAP);
            // R11: contents undefined after deep sleep until a new write
            if (state_ff == PSC_SLEEP) begin
                data_lost_o <= 1'b1;
            end else if (take && q_data[CMD_WR_BIT]) begin
                data_lost_o <= 1'b0;
            end
        end
    end
endmodule : psc_ctrl

// [include/psc_pkg.sv]
// Constants and types for the pseudo-static RAM host controller
package psc_pkg;
    // Clock rate
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 20;
    // Widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int CMD_W = ADDR_W + DATA_W + 3;
    // Times in their own units
    localparam int POWERUP_US = 200;
    localparam int BURST_MAX_US = 40;
    localparam int SLEEP_WE_MAX_US = 1;
    localparam int SLEEP_MIN_US = 10;
    localparam int WAKE_US = 200;
    localparam int CYCLE_MIN_NS = 70;
    localparam int WRITE_PULSE_NS = 50;
    localparam int SELECT_END_NS = 60;
    localparam int DATA_SETUP_NS = 20;
    localparam int SELECT_HIGH_NS = 10;
    // Least times round up, longest times round down
    localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int BURST_MAX_CYC = BURST_MAX_US * CLK_MHZ;
    localparam int SLEEP_MIN_CYC = SLEEP_MIN_US * CLK_MHZ;
    localparam int SLEEP_WE_CYC = (SLEEP_WE_MAX_US * CLK_MHZ) / 2;
    localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CW_CYC = (SELECT_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DW_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Counter width
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    // Command fields
    localparam int CMD_WR_BIT = CMD_W - 1;
    localparam int CMD_HI_BIT = CMD_W - 2;
    localparam int CMD_LO_BIT = CMD_W - 3;
    // Controller states
    typedef enum logic [6:0] {
        PSC_POWERUP = 7'h01,
        PSC_IDLE    = 7'h02,
        PSC_ACCESS  = 7'h04,
        PSC_GAP     = 7'h08,
        PSC_SLEEPWE = 7'h10,
        PSC_SLEEP   = 7'h20,
        PSC_WAKE    = 7'h40
    } psc_state_t;
endpackage : psc_pkg

// [sim/psc_monitor.sv]
// Pin timing checker for the RAM host controller
`timescale 1ns/1ps
module psc_monitor #(
    parameter int POWERUP_CYCLES = 20,
    parameter int WAKE_CYCLES = 20,
    parameter int BURST_CYCLES = 400,
    parameter int SLEEP_CYCLES = 10
) (
    // Clock, reset and strobes
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ram_select_n_o,
    input wire logic ram_read_drive_n_o,
    input wire logic ram_write_strobe_n_o,
    input wire logic high_lane_enable_n_o,
    input wire logic low_lane_enable_n_o,
    input wire logic sleep_request_n_o,
    // Bus
    input wire logic [18:0] ram_addr_o,
    input wire logic ram_data_oe_o
);
    localparam int WE_MAX = 50;
    logic [15:0] quiet_ff, slp_ff, busy_ff;
    logic woke_ff;
    logic [1:0] hi_ff;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Cycles since reset release or since the sleep pin rose
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            quiet_ff <= 16'h0000;
            woke_ff <= 1'b0;
        end else if (!sleep_request_n_o) begin
            quiet_ff <= 16'h0000;
            woke_ff <= 1'b1;
        end else if (quiet_ff != 16'hffff) begin
            quiet_ff <= quiet_ff + 16'h0001;
        end
    end
    // Length of the current deep sleep
    always_ff @(posedge clk_i) begin
        slp_ff <= (!resetn_i || sleep_request_n_o) ? 16'h0000 : slp_ff + 16'h0001;
    end
    // Busy span, cleared only by a rest of three or more idle cycles
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hi_ff <= 2'h0;
            busy_ff <= 16'h0000;
        end else begin
            hi_ff <= !ram_select_n_o ? 2'h0 : (hi_ff == 2'h3 ? hi_ff : hi_ff + 2'h1);
            busy_ff <= (hi_ff == 2'h3) ? 16'h0000 : busy_ff + 16'h0001;
        end
    end
    sequence pulse_s;
        !ram_write_strobe_n_o [*3] ##1 ram_write_strobe_n_o;
    endsequence
    sequence end_s;
        ram_select_n_o && $stable(ram_addr_o);
    endsequence
    powerup_hold_a: assert property (!woke_ff && quiet_ff < POWERUP_CYCLES |-> ram_select_n_o) else $error("select low during power-up wait");
    write_overlap_a: assert property (!ram_write_strobe_n_o && sleep_request_n_o |-> !ram_select_n_o && ram_data_oe_o) else $error("strobe low outside select");
    write_width_a: assert property ($fell(ram_write_strobe_n_o) && sleep_request_n_o |-> pulse_s) else $error("write pulse not three cycles");
    lane_choice_a: assert property ((!ram_write_strobe_n_o || !ram_read_drive_n_o) && sleep_request_n_o |-> !(high_lane_enable_n_o && low_lane_enable_n_o)) else $error("access with no lane");
    write_end_a: assert property ($rose(ram_write_strobe_n_o) && sleep_request_n_o |-> end_s) else $error("address moved at write end");
    burst_rest_a: assert property (busy_ff <= BURST_CYCLES) else $error("sustained access too long");
    data_release_a: assert property (ram_data_oe_o |-> !ram_select_n_o && ram_read_drive_n_o) else $error("data driven outside write");
    sleep_entry_a: assert property ($fell(sleep_request_n_o) |-> ##[0:WE_MAX] !ram_write_strobe_n_o) else $error("strobe late after sleep");
    sleep_hold_a: assert property ($rose(sleep_request_n_o) |-> $past(slp_ff) >= SLEEP_CYCLES - 1) else $error("sleep too short");
    wake_wait_a: assert property (woke_ff && quiet_ff < WAKE_CYCLES |-> ram_select_n_o) else $error("select low during wake wait");
endmodule : psc_monitor
bind psc_ctrl psc_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES), .BURST_CYCLES(BURST_CYCLES),
    .SLEEP_CYCLES(SLEEP_CYCLES)) u_psc_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .ram_select_n_o(ram_select_n_o),
    .ram_read_drive_n_o(ram_read_drive_n_o), .ram_write_strobe_n_o(ram_write_strobe_n_o),
    .high_lane_enable_n_o(high_lane_enable_n_o), .low_lane_enable_n_o(low_lane_enable_n_o),
    .sleep_request_n_o(sleep_request_n_o), .ram_addr_o(ram_addr_o), .ram_data_oe_o(ram_data_oe_o));

// [sim/psc_ram_model.sv]
// Behavioural model of the pseudo-static RAM pins
`timescale 1ns/1ps
module psc_ram_model (
    // Pattern clock and strobes
    input wire logic clk_i,
    input wire logic sel_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic hi_n_i,
    input wire logic lo_n_i,
    input wire logic slp_n_i,
    // Bus
    input wire logic [18:0] addr_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o
);
    logic [15:0] mem [256];
    logic [15:0] held = 16'h0000;
    wire wr_on = !sel_n_i && !wr_n_i && slp_n_i;
    wire rd_on = !sel_n_i && !rd_n_i && wr_n_i;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
    // each clock beat of the overlap stores the chosen lanes
    // so the last beat before select or strobe rises is what stays
    always @(posedge clk_i) if (wr_on) begin
        if (!hi_n_i) mem[addr_i[7:0]][15:8] = data_i[15:8];
        if (!lo_n_i) mem[addr_i[7:0]][7:0] = data_i[7:0];
    end
    // released lanes show the inverse of the last value
    assign data_o[15:8] = (rd_on && !hi_n_i) ? mem[addr_i[7:0]][15:8] : ~held[15:8];
    assign data_o[7:0] = (rd_on && !lo_n_i) ? mem[addr_i[7:0]][7:0] : ~held[7:0];
    always @(posedge clk_i) held <= data_o;
    always @(negedge slp_n_i) for (int i = 0; i < 256; i++) mem[i] = 16'h5a5a;
endmodule : psc_ram_model

// [sim/test_psc_ctrl.sv]
// Self-checking bench for the RAM host controller
`timescale 1ns/1ps
module test_psc_ctrl;
    import psc_pkg::*;
    localparam int PU = 20, WK = 20, BU = 400, SL = 10;
    logic clk_i = 0, resetn_i = 0, cmd_valid_i = 0, cmd_write_i = 0, cmd_high_i = 0, cmd_low_i = 0, sleep_req_i = 0;
    logic [ADDR_W-1:0] cmd_addr_i = 0, ram_addr_o;
    logic [DATA_W-1:0] cmd_wdata_i = 0, rd_data_o, ram_data_o, ram_data_i;
    logic cmd_ready_o, rd_valid_o, ready_o, data_lost_o, sel_n, rd_n, wr_n, hi_n, lo_n, slp_n, oe;
    int errors = 0, tests_run = 0, n, l;
    logic chk_rd = 1;
    logic [15:0] shadow [256];
    logic [15:0] exp_q [$], msk_q [$];
    psc_ctrl #(.POWERUP_CYCLES(PU), .WAKE_CYCLES(WK), .BURST_CYCLES(BU), .SLEEP_CYCLES(SL)) u_psc_ctrl (
        .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .cmd_write_i(cmd_write_i), .cmd_high_i(cmd_high_i), .cmd_low_i(cmd_low_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .sleep_req_i(sleep_req_i),
        .ready_o(ready_o), .data_lost_o(data_lost_o), .ram_select_n_o(sel_n), .ram_read_drive_n_o(rd_n),
        .ram_write_strobe_n_o(wr_n), .high_lane_enable_n_o(hi_n), .low_lane_enable_n_o(lo_n),
        .sleep_request_n_o(slp_n), .ram_addr_o(ram_addr_o), .ram_data_o(ram_data_o), .ram_data_oe_o(oe),
        .ram_data_i(ram_data_i));
    psc_ram_model u_psc_ram_model (.clk_i(clk_i), .sel_n_i(sel_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .hi_n_i(hi_n),
        .lo_n_i(lo_n), .slp_n_i(slp_n), .addr_i(ram_addr_o), .data_i(ram_data_o), .data_o(ram_data_i));
    initial forever #10 clk_i = ~clk_i;
    // Word after a lane-masked write
    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] d, logic h, logic lo);
        return {h ? d[15:8] : o[15:8], lo ? d[7:0] : o[7:0]};
    endfunction : merge
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Offer one command from a falling edge and hold it until taken
    task automatic push(logic w, logic h, logic lo, logic [18:0] a, logic [15:0] d);
        cmd_valid_i = 1;
        cmd_write_i = w;
        cmd_high_i = h;
        cmd_low_i = lo;
        cmd_addr_i = a;
        cmd_wdata_i = d;
        @(posedge clk_i);
        while (cmd_ready_o !== 1'b1) @(posedge clk_i);
        if (w) shadow[a[7:0]] = merge(shadow[a[7:0]], d, h, lo);
        else if (chk_rd && (h || lo)) begin
            exp_q.push_back(shadow[a[7:0]]);
            msk_q.push_back({{8{h}}, {8{lo}}});
        end
        @(negedge clk_i);
    endtask : push
    // Close a batch with a read and wait for every answer
    task automatic drain();
        push(0, 1, 1, 19'h00000, 16'h0000);
        cmd_valid_i = 0;
        for (n = 0; n < 2000 && exp_q.size() != 0; n++) @(negedge clk_i);
        check("reads pending", 16'(exp_q.size()), 16'h0000);
    endtask : drain
    // Every answer against the shadow, selected lanes only
    always @(negedge clk_i) begin : read_check
        logic [15:0] e, m;
        if (rd_valid_o === 1'b1 && chk_rd) begin
            if (exp_q.size() == 0) begin
                check("read count", 16'h0001, 16'h0000);
            end else begin
                e = exp_q.pop_front();
                m = msk_q.pop_front();
                check("read data", rd_data_o & m, e & m);
            end
        end
    end
    initial begin
        #(CLK_PERIOD_NS * 20000);
        errors++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hfd2e));
        for (int i = 0; i < 256; i++) shadow[i] = 16'h0000;
        repeat (2) @(negedge clk_i);
        resetn_i = 1;
        for (n = 0; n < 200 && ready_o !== 1'b1; n++) @(negedge clk_i);
        check("powerup wait", 16'(n >= PU - 1 && n < 200), 16'h0001);
        // Aliased lanes, a laneless write, then random batches
        push(1, 1, 0, 19'h7ffff, 16'hbeef);
        push(1, 0, 1, 19'h000ff, 16'h1234);
        push(1, 0, 0, 19'h000ff, 16'hffff);
        push(0, 1, 1, 19'h7ffff, 16'h0000);
        push(0, 0, 1, 19'h000ff, 16'h0000);
        for (int b = 0; b < 3; b++) begin
            for (int i = 0; i < 12; i++) begin
                l = 1 + $urandom % 3;
                push(1'($urandom), l[1], l[0], 19'($urandom), 16'($urandom));
            end
            drain();
        end
        // Deep sleep: queue until full, wake, rewrite, read back
        sleep_req_i = 1;
        for (n = 0; n < 100 && slp_n !== 1'b0; n++) @(negedge clk_i);
        check("sleep pin", 16'(slp_n), 16'h0000);
        for (int i = 0; i < 256; i++) shadow[i] = 16'h5a5a;
        for (n = 0; n < 40 && cmd_ready_o === 1'b1; n++) push(1, n[0], 1, 19'(n), 16'($urandom));
        cmd_valid_i = 0;
        check("fifo depth", 16'(n), 16'(FIFO_DEPTH));
        repeat (SL + 5) @(negedge clk_i);
        sleep_req_i = 0;
        check("data lost", 16'(data_lost_o), 16'h0001);
        for (n = 0; n < 500 && ready_o !== 1'b1; n++) @(negedge clk_i);
        check("wake wait", 16'(n >= WK && n < 500), 16'h0001);
        for (int i = 0; i < 20; i++) push(0, 1, 1, 19'(i), 16'h0000);
        drain();
        check("data lost clear", 16'(data_lost_o), 16'h0000);
        // Sustained writes of one value force a rest
        push(1, 1, 1, 19'h00080, 16'haaaa);
        for (int i = 0; i < 100; i++) push(1, 1, 1, 19'h00080, 16'haaaa);
        push(0, 1, 1, 19'h00080, 16'h0000);
        drain();
        complete_run();
    end
endmodule : test_psc_ctrl
